//--- tcc_timer_ctrl.sv
// Purpose: control, flags and pin actions of an eight-channel timer
// Assumes: register port and pins synchronous to clock
// Notes:   read data stand one cycle after the read strobe only
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module tcc_timer_ctrl #(
    parameter int CH = 8
) (
    input  wire logic                clock,
    input  wire logic                rstn,
    input  wire tcc_pkg::tcc_bus_req_t bus_req,
    output logic [7:0]               rd_data,
    input  wire logic [CH-1:0]       cap_in,
    output tcc_pkg::tcc_pin_t        pin,
    output logic [CH-1:0]            chan_irq,
    output logic                     ovf_irq
);
    // byte-wide registers hold exactly eight channels
    if (CH != 8) begin : g_bad_ch
        $error("tcc_timer_ctrl serves exactly eight channels");
    end

    logic [7:0]  sel_reg;
    logic [7:0]  disc_reg;
    logic [7:0]  mask_reg;
    logic [7:0]  sc1_reg;
    logic        prec_lock_reg;
    logic [15:0] act_reg;
    logic [15:0] edg_reg;
    logic [7:0]  tie_reg;
    logic [7:0]  sc2_reg;
    logic [7:0]  acctl_reg;
    logic [7:0]  ptps_reg;
    logic [7:0]  flg_reg;
    logic        ovf_reg;
    logic [15:0] cnt_reg;
    logic [15:0] pa_cnt_reg;
    logic [15:0] tc_reg [CH];
    logic [7:0]  prev_reg;
    logic [7:0]  out_reg;
    logic [7:0]  rd_data_reg;

    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [7:0]  wdata;
    logic        timer_run_enable;
    logic        acen;
    logic        fast;
    logic        clr7;
    logic        tick;
    logic        in_tc;
    logic        w1c_ok;
    logic [7:0]  match;
    logic [7:0]  cap_evt;
    logic [7:0]  fclr;
    logic [7:0]  out_next;
    logic [7:0]  flg_clr;
    logic        ovf_evt;
    logic        ovf_clr;
    logic        pa_edge;
    logic [7:0]  rd_mux;

    // request fields and control bits
    assign wr     = bus_req.wr;
    assign rd     = bus_req.rd;
    assign addr   = bus_req.addr;
    assign wdata  = bus_req.wdata;
    assign timer_run_enable    = sc1_reg[tcc_pkg::SC1_TEN];
    assign acen   = acctl_reg[tcc_pkg::PA_EN];
    assign fast   = sc1_reg[tcc_pkg::SC1_FFCA];
    assign clr7   = sc2_reg[tcc_pkg::SC2_CLR7];
    assign in_tc  = addr[5:4] == tcc_pkg::A_TC[5:4];
    assign w1c_ok = timer_run_enable || acen;

    // prescaler runs only with the timer enabled
    tcc_prescaler u_pre (
        .clock   (clock),
        .rstn    (rstn),
        .run     (timer_run_enable),
        .precise (sc1_reg[tcc_pkg::SC1_PREC]),
        .select  (sc2_reg[tcc_pkg::SC2_PR_HI:0]),
        .ptps    (ptps_reg),
        .tick    (tick)
    );

    // per-channel compare, capture, fast clear and pin logic
    for (genvar i = 0; i < CH; i++) begin : g_ch
        logic om;
        logic ol;
        logic rise;
        logic fall;
        assign om   = act_reg[2*i+1];
        assign ol   = act_reg[2*i];
        assign rise = cap_in[i] && !prev_reg[i];
        assign fall = !cap_in[i] && prev_reg[i];
        assign match[i] = sel_reg[i] && tick && cnt_reg == tc_reg[i];
        // upper bit is falling, lower bit is rising
        assign cap_evt[i] = !sel_reg[i] && timer_run_enable
                          && ((edg_reg[2*i] && rise) || (edg_reg[2*i+1] && fall));
        assign fclr[i] = fast && in_tc && addr[3:1] == 3'(i)
                       && ((rd && !sel_reg[i]) || (wr && sel_reg[i]));
        // masked or disconnected channels keep their line
        always_comb begin
            out_next[i] = out_reg[i];
            if (match[i] && !mask_reg[i] && !disc_reg[i]) begin
                unique case ({om, ol})
                    2'b00: out_next[i] = out_reg[i];
                    2'b01: out_next[i] = !out_reg[i];
                    2'b10: out_next[i] = 1'b0;
                    2'b11: out_next[i] = 1'b1;
                endcase
            end
        end
        assign pin.oe[i] = (om || ol) && !disc_reg[i];
    end

    assign pin.out = out_reg;

    // compare line state and input history
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            out_reg  <= tcc_pkg::RST_BYTE;
            prev_reg <= tcc_pkg::RST_BYTE;
        end else begin
            out_reg  <= out_next;
            prev_reg <= cap_in;
        end
    end

    // configuration writes; the precision bit takes one write only
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sel_reg       <= tcc_pkg::RST_BYTE;
            disc_reg      <= tcc_pkg::RST_BYTE;
            mask_reg      <= tcc_pkg::RST_BYTE;
            sc1_reg       <= tcc_pkg::RST_BYTE;
            prec_lock_reg <= 1'b0;
            act_reg       <= tcc_pkg::RST_WORD;
            edg_reg       <= tcc_pkg::RST_WORD;
            tie_reg       <= tcc_pkg::RST_BYTE;
            sc2_reg       <= tcc_pkg::RST_BYTE;
            acctl_reg     <= tcc_pkg::RST_BYTE;
            ptps_reg      <= tcc_pkg::RST_BYTE;
        end else if (wr) begin
            unique case (addr)
                tcc_pkg::A_SEL:    sel_reg <= wdata;
                tcc_pkg::A_DISC:   disc_reg <= wdata;
                tcc_pkg::A_MASK:   mask_reg <= wdata;
                tcc_pkg::A_SC1: begin
                    sc1_reg <= wdata;
                    if (prec_lock_reg) begin
                        sc1_reg[tcc_pkg::SC1_PREC] <= sc1_reg[tcc_pkg::SC1_PREC];
                    end
                    prec_lock_reg <= 1'b1;
                end
                tcc_pkg::A_ACT_HI: act_reg[15:8] <= wdata;
                tcc_pkg::A_ACT_LO: act_reg[7:0] <= wdata;
                tcc_pkg::A_EDG_HI: edg_reg[15:8] <= wdata;
                tcc_pkg::A_EDG_LO: edg_reg[7:0] <= wdata;
                tcc_pkg::A_TIE:    tie_reg <= wdata;
                tcc_pkg::A_SC2:    sc2_reg <= wdata;
                tcc_pkg::A_ACCTL:  acctl_reg <= wdata;
                tcc_pkg::A_PTPS:   ptps_reg <= wdata;
                default: ;
            endcase
        end
    end

    // value registers: software writes in compare mode, capture latches count
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int k = 0; k < CH; k++) begin
                tc_reg[k] <= tcc_pkg::RST_WORD;
            end
        end else begin
            for (int k = 0; k < CH; k++) begin
                if (cap_evt[k]) begin
                    tc_reg[k] <= cnt_reg;
                end else if (wr && in_tc && addr[3:1] == 3'(k) && sel_reg[k]) begin
                    if (addr[0]) begin
                        tc_reg[k][7:0] <= wdata;
                    end else begin
                        tc_reg[k][15:8] <= wdata;
                    end
                end
            end
        end
    end

    // free-running counter, stopped while the timer is off
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= tcc_pkg::RST_WORD;
        end else if (timer_run_enable && tick) begin
            if (clr7 && match[7]) begin
                cnt_reg <= tcc_pkg::RST_WORD;
            end else begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end

    // a modulus reset at the top is not an overflow
    assign ovf_evt = timer_run_enable && tick && cnt_reg == tcc_pkg::CNT_TOP
                   && !(clr7 && match[7]);

    // channel flags; set beats a clear in the same cycle
    assign flg_clr = ((wr && w1c_ok && addr == tcc_pkg::A_FLG1) ? wdata : 8'h00)
                   | fclr;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flg_reg <= tcc_pkg::RST_BYTE;
        end else begin
            flg_reg <= (flg_reg & ~flg_clr) | match | cap_evt;
        end
    end

    // overflow flag, cleared by write one or fast counter access
    assign ovf_clr = (wr && w1c_ok && addr == tcc_pkg::A_FLG2
                      && wdata[tcc_pkg::FLG2_OVF])
                   || (fast && (rd || wr)
                       && (addr == tcc_pkg::A_CNT_HI || addr == tcc_pkg::A_CNT_LO));
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ovf_reg <= 1'b0;
        end else begin
            ovf_reg <= (ovf_reg && !ovf_clr) || ovf_evt;
        end
    end

    // pulse accumulator on pin 7, alive without the timer run bit
    assign pa_edge = acctl_reg[tcc_pkg::PA_EDGE] ? (cap_in[7] && !prev_reg[7])
                                                 : (!cap_in[7] && prev_reg[7]);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pa_cnt_reg <= tcc_pkg::RST_WORD;
        end else if (acen && pa_edge) begin
            pa_cnt_reg <= pa_cnt_reg + 16'h0001;
        end
    end

    // interrupt requests are plain levels of flag and enable
    assign chan_irq = flg_reg & tie_reg;
    assign ovf_irq  = ovf_reg && sc2_reg[tcc_pkg::SC2_OIE];

    // read selection; unmapped bytes read zero
    always_comb begin
        rd_mux = 8'h00;
        if (in_tc) begin
            rd_mux = addr[0] ? tc_reg[addr[3:1]][7:0] : tc_reg[addr[3:1]][15:8];
        end else begin
            unique case (addr)
                tcc_pkg::A_SEL:    rd_mux = sel_reg;
                tcc_pkg::A_DISC:   rd_mux = disc_reg;
                tcc_pkg::A_MASK:   rd_mux = mask_reg;
                tcc_pkg::A_CNT_HI: rd_mux = cnt_reg[15:8];
                tcc_pkg::A_CNT_LO: rd_mux = cnt_reg[7:0];
                tcc_pkg::A_SC1:    rd_mux = sc1_reg;
                tcc_pkg::A_ACT_HI: rd_mux = act_reg[15:8];
                tcc_pkg::A_ACT_LO: rd_mux = act_reg[7:0];
                tcc_pkg::A_EDG_HI: rd_mux = edg_reg[15:8];
                tcc_pkg::A_EDG_LO: rd_mux = edg_reg[7:0];
                tcc_pkg::A_TIE:    rd_mux = tie_reg;
                tcc_pkg::A_SC2:    rd_mux = sc2_reg;
                tcc_pkg::A_FLG1:   rd_mux = flg_reg;
                tcc_pkg::A_FLG2:   rd_mux = {ovf_reg, 7'h00};
                tcc_pkg::A_ACCTL:  rd_mux = acctl_reg;
                tcc_pkg::A_PA_HI:  rd_mux = pa_cnt_reg[15:8];
                tcc_pkg::A_PA_LO:  rd_mux = pa_cnt_reg[7:0];
                tcc_pkg::A_PTPS:   rd_mux = ptps_reg;
                default:           rd_mux = 8'h00;
            endcase
        end
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_data_reg <= tcc_pkg::RST_BYTE;
        end else begin
            rd_data_reg <= rd ? rd_mux : 8'h00;
        end
    end

    assign rd_data = rd_data_reg;

    property p_toggle;
        @(posedge clock) disable iff (!rstn)
        (match[1] && act_reg[3:2] == 2'b01 && !mask_reg[1] && !disc_reg[1])
        |=> out_reg[1] != $past(out_reg[1]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("channel 1 did not toggle");

    property p_modulus;
        @(posedge clock) disable iff (!rstn)
        (timer_run_enable && tick && clr7 && match[7]) |=> cnt_reg == 16'h0000;
    endproperty
    a_modulus: assert property (p_modulus) else $error("counter not cleared");

    property p_stuck_zero;
        @(posedge clock) disable iff (!rstn)
        (timer_run_enable && clr7 && sel_reg[7] && tc_reg[7] == 16'h0000 && cnt_reg == 16'h0000
         && !cap_evt[7] && !(wr && in_tc))
        |=> cnt_reg == 16'h0000;
    endproperty
    a_stuck_zero: assert property (p_stuck_zero) else $error("counter left zero");

    property p_no_ovf_top;
        @(posedge clock) disable iff (!rstn)
        (tick && clr7 && match[7] && cnt_reg == 16'hFFFF && !ovf_reg)
        |=> !ovf_reg && cnt_reg == 16'h0000;
    endproperty
    a_no_ovf_top: assert property (p_no_ovf_top) else $error("overflow on modulus");

    property p_ovf_set;
        @(posedge clock) disable iff (!rstn)
        (timer_run_enable && tick && cnt_reg == 16'hFFFF && !(clr7 && match[7]))
        |=> ovf_reg && cnt_reg == 16'h0000;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("rollover missed");

    property p_w1c_locked;
        @(posedge clock) disable iff (!rstn)
        (!timer_run_enable && !acen && wr && addr == tcc_pkg::A_FLG1) |=> flg_reg == $past(flg_reg);
    endproperty
    a_w1c_locked: assert property (p_w1c_locked) else $error("flag cleared while off");

    property p_zero_keeps;
        @(posedge clock) disable iff (!rstn)
        (wr && addr == tcc_pkg::A_FLG1 && wdata == 8'h00 && fclr == 8'h00)
        |=> (flg_reg & $past(flg_reg)) == $past(flg_reg);
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared");

    property p_fast_ovf;
        @(posedge clock) disable iff (!rstn)
        (fast && rd && addr == tcc_pkg::A_CNT_LO && !ovf_evt) |=> !ovf_reg;
    endproperty
    a_fast_ovf: assert property (p_fast_ovf) else $error("fast clear missed");

    property p_stopped;
        @(posedge clock) disable iff (!rstn)
        !timer_run_enable |=> $stable(cnt_reg);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter ran while off");

    property p_irq_follow;
        @(posedge clock) disable iff (!rstn)
        (cap_evt[0] && tie_reg[0] && !(wr && addr == tcc_pkg::A_TIE)) |=> chan_irq[0];
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("channel request missing");
endmodule : tcc_timer_ctrl

//--- tcc_pkg.sv
// Purpose: shared constants and carrier types of the timer control block
// Assumes: byte-wide register port, 6-bit byte address
// Notes:   offsets are byte addresses on the plain register port
package tcc_pkg;
    localparam int ADDR_W = 6;
    // register offsets
    localparam logic [5:0] A_SEL    = 6'h00;
    localparam logic [5:0] A_DISC   = 6'h01;
    localparam logic [5:0] A_MASK   = 6'h02;
    localparam logic [5:0] A_CNT_HI = 6'h04;
    localparam logic [5:0] A_CNT_LO = 6'h05;
    localparam logic [5:0] A_SC1    = 6'h06;
    localparam logic [5:0] A_ACT_HI = 6'h08;
    localparam logic [5:0] A_ACT_LO = 6'h09;
    localparam logic [5:0] A_EDG_HI = 6'h0A;
    localparam logic [5:0] A_EDG_LO = 6'h0B;
    localparam logic [5:0] A_TIE    = 6'h0C;
    localparam logic [5:0] A_SC2    = 6'h0D;
    localparam logic [5:0] A_FLG1   = 6'h0E;
    localparam logic [5:0] A_FLG2   = 6'h0F;
    localparam logic [5:0] A_TC     = 6'h10;
    localparam logic [5:0] A_ACCTL  = 6'h20;
    localparam logic [5:0] A_PA_HI  = 6'h22;
    localparam logic [5:0] A_PA_LO  = 6'h23;
    localparam logic [5:0] A_PTPS   = 6'h2B;
    // field positions
    localparam int SC1_TEN  = 7;
    localparam int SC1_FFCA = 4;
    localparam int SC1_PREC = 3;
    localparam int SC2_OIE  = 7;
    localparam int SC2_CLR7 = 3;
    localparam int SC2_PR_HI = 2;
    localparam int FLG2_OVF = 7;
    localparam int PA_EN    = 6;
    localparam int PA_EDGE  = 4;
    // values after reset and counter top
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] CNT_TOP  = 16'hFFFF;

    // one register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } tcc_bus_req_t;

    // timer pins, driven side
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } tcc_pin_t;
endpackage : tcc_pkg

//--- tcc_prescaler.sv
// Purpose: bus clock prescaler making the timer count tick
// Assumes: run low holds all stages at zero
// Notes:   a new factor loads when the stages wrap to zero and on every cycle while run is low
`timescale 1ns/10ps
module tcc_prescaler (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic       precise,
    input  wire logic [2:0] select,
    input  wire logic [7:0] ptps,
    output logic            tick
);
    logic [7:0] cnt_reg;
    logic [7:0] div_reg;
    logic [7:0] div_next;

    // legacy factor is two to the select, precision is ptps plus one
    assign div_next = precise ? ptps : ~(8'hFF << select);
    assign tick     = run && (cnt_reg == div_reg);

    // factor is taken only where all stages are zero, avoiding a short period
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= tcc_pkg::RST_BYTE;
            div_reg <= tcc_pkg::RST_BYTE;
        end else if (!run || cnt_reg == div_reg) begin
            cnt_reg <= tcc_pkg::RST_BYTE;
            div_reg <= div_next;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    property p_pre_slow;
        @(posedge clock) disable iff (!rstn)
        (tick && div_next != 8'h00) |=> !tick;
    endproperty
    a_pre_slow: assert property (p_pre_slow) else $error("prescaler ticked twice");

    property p_pre_hold;
        @(posedge clock) disable iff (!rstn)
        (run && cnt_reg != 8'h00 && cnt_reg != div_reg) |=> $stable(div_reg);
    endproperty
    a_pre_hold: assert property (p_pre_hold) else $error("factor changed mid period");
endmodule : tcc_prescaler

//--- tcc_pin_model.sv
// Purpose: far side of the timer pins
// Assumes: pin lines sampled on the bus clock
// Notes:   a driven pin loops back, an undriven one follows the bench level
`timescale 1ns/10ps
module tcc_pin_model (
    input  wire logic              clock,
    input  wire logic [7:0]        level,
    input  wire tcc_pkg::tcc_pin_t pin,
    output logic [7:0]             cap_in
);
    // start low so capture never sees an unknown first sample
    initial cap_in = 8'h00;
    // wire level resolved from the device enable and the outside source
    always @(posedge clock) begin
        cap_in <= (pin.out & pin.oe) | (level & ~pin.oe);
    end
endmodule : tcc_pin_model

//--- tb_timer_compare_capture_ctrl.sv
// Purpose: self-checking bench of the timer control block
// Assumes: 25 MHz clock, register port answers without waiting
// Notes:   one full counter wrap is needed for the overflow test
`timescale 1ns/10ps
module tb_timer_compare_capture_ctrl;
    logic                  clock;
    logic                  rstn;
    tcc_pkg::tcc_bus_req_t bus_req;
    logic [7:0]            rd_data;
    logic [7:0]            cap_in;
    tcc_pkg::tcc_pin_t     pin;
    logic [7:0]            chan_irq;
    logic                  ovf_irq;
    logic [7:0]            level;
    int                    failures;
    int                    checks;
    int                    cyc;
    int                    seed;
    logic [7:0]            exp_q[$];
    logic [7:0]            got;
    logic                  exp_out;
    int                    ta;
    int                    tb;

    tcc_timer_ctrl #(.CH(8)) tcc_timer_ctrl_inst (
        .clock(clock), .rstn(rstn), .bus_req(bus_req), .rd_data(rd_data),
        .cap_in(cap_in), .pin(pin), .chan_irq(chan_irq), .ovf_irq(ovf_irq));
    tcc_pin_model tcc_pin_model_inst (
        .clock(clock), .level(level), .pin(pin), .cap_in(cap_in));

    // free clock and cycle count for period measurement
    initial clock = 1'b0;
    always #20 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        bus_req.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clock);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        bus_req.rd <= 1'b0;
        #1 d = rd_data;
    endtask : rd

    task automatic set_level(input logic [7:0] v);
        @(posedge clock);
        level <= v;
        repeat (4) @(posedge clock);
    endtask : set_level

    // bounded wait for the channel 1 request, returns the cycle seen
    task automatic wait_ch1(output int t);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            #1 n++;
        end while (chan_irq[1] !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            failures++;
            $display("BAD channel 1 match expected 1 seen 0");
        end
        t = cyc;
    endtask : wait_ch1

    task automatic end_test(input string name);
        $display("test %s finished, checks %0d", name, checks);
    endtask : end_test

    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // whole run needs about 70000 cycles
    initial begin
        repeat (90000) @(posedge clock);
        failures++;
        report_and_stop();
    end

    initial begin
        seed = 32'h2bcd7a31;
        bus_req = '0;
        level = 8'h00;
        rstn = 1'b0;
        failures = 0;
        checks = 0;
        cyc = 0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        // reset values, unmapped read, random readback
        for (int a = 8; a < 16; a++) begin
            rd(a[5:0], got);
            chk("reset value", 16'h0000, {8'h00, got});
        end
        rd(6'h3F, got);
        chk("unmapped read", 16'h0000, {8'h00, got});
        for (int a = 8; a < 13; a++) begin
            exp_q.push_back(8'($random(seed)));
            wr(a[5:0], exp_q[$]);
            rd(a[5:0], got);
            chk("readback", {8'h00, exp_q.pop_front()}, {8'h00, got});
            wr(a[5:0], 8'h00);
        end
        end_test("registers");
        // channel 7 compare at zero with clear on match holds the counter
        wr(tcc_pkg::A_SEL, 8'h80);
        wr(tcc_pkg::A_SC2, 8'h08);
        wr(tcc_pkg::A_SC1, 8'h80);
        repeat (20) @(posedge clock);
        rd(tcc_pkg::A_CNT_HI, got);
        chk("count high", 16'h0000, {8'h00, got});
        rd(tcc_pkg::A_CNT_LO, got);
        chk("count low", 16'h0000, {8'h00, got});
        // every edge mode on channel 0, rising then falling
        for (int m = 0; m < 4; m++) begin
            wr(tcc_pkg::A_EDG_LO, m[7:0]);
            wr(tcc_pkg::A_FLG1, 8'h01);
            set_level(8'h01);
            rd(tcc_pkg::A_FLG1, got);
            chk("rise flag", {15'h0, m[0]}, {15'h0, got[0]});
            wr(tcc_pkg::A_FLG1, 8'h01);
            set_level(8'h00);
            rd(tcc_pkg::A_FLG1, got);
            chk("fall flag", {15'h0, m[1]}, {15'h0, got[0]});
        end
        wr(tcc_pkg::A_TIE, 8'h00);
        #1 chk("masked request", 16'h0000, {15'h0, chan_irq[0]});
        wr(tcc_pkg::A_TIE, 8'h01);
        #1 chk("channel request", 16'h0001, {15'h0, chan_irq[0]});
        wr(tcc_pkg::A_FLG1, 8'h00);
        rd(tcc_pkg::A_FLG1, got);
        chk("zero write", 16'h0001, {15'h0, got[0]});
        wr(tcc_pkg::A_SC1, 8'h00);
        wr(tcc_pkg::A_FLG1, 8'h01);
        rd(tcc_pkg::A_FLG1, got);
        chk("clear when off", 16'h0001, {15'h0, got[0]});
        wr(tcc_pkg::A_ACCTL, 8'h40);
        wr(tcc_pkg::A_FLG1, 8'h01);
        rd(tcc_pkg::A_FLG1, got);
        chk("clear by accum", 16'h0000, {15'h0, got[0]});
        wr(tcc_pkg::A_ACCTL, 8'h00);
        // fast clear through a read of the capture value
        wr(tcc_pkg::A_SC1, 8'h90);
        set_level(8'h01);
        rd(tcc_pkg::A_FLG1, got);
        chk("capture flag", 16'h0001, {15'h0, got[0]});
        rd(tcc_pkg::A_CNT_LO, got);
        chk("count held", 16'h0000, {8'h00, got});
        rd(tcc_pkg::A_TC, got);
        rd(tcc_pkg::A_FLG1, got);
        chk("fast clear", 16'h0000, {15'h0, got[0]});
        wr(tcc_pkg::A_SC1, 8'h80);
        end_test("capture");
        // channel 1 compares at 0x20 inside a 0x40 modulus
        wr(tcc_pkg::A_SEL, 8'h82);
        wr(tcc_pkg::A_TC + 6'd14, 8'h00);
        wr(tcc_pkg::A_TC + 6'd15, 8'h40);
        wr(tcc_pkg::A_TC + 6'd2, 8'h00);
        wr(tcc_pkg::A_TC + 6'd3, 8'h20);
        wr(tcc_pkg::A_TIE, 8'h02);
        exp_out = 1'b0;
        for (int m = 0; m < 4; m++) begin
            wr(tcc_pkg::A_ACT_LO, 8'(m << 2));
            #1 chk("drive enable", {15'h0, m != 0}, {15'h0, pin.oe[1]});
            wr(tcc_pkg::A_FLG1, 8'h02);
            wait_ch1(ta);
            exp_out = (m == 1) ? ~exp_out : (m == 0) ? exp_out : m[0];
            chk("compare out", {15'h0, exp_out}, {15'h0, pin.out[1]});
        end
        // disconnect, then override mask, each blocks a toggle
        for (int k = 0; k < 2; k++) begin
            wr(k ? tcc_pkg::A_MASK : tcc_pkg::A_DISC, 8'h02);
            wr(tcc_pkg::A_ACT_LO, 8'h04);
            wr(tcc_pkg::A_FLG1, 8'h02);
            wait_ch1(ta);
            chk("blocked out", {15'h0, exp_out}, {15'h0, pin.out[1]});
            wr(k ? tcc_pkg::A_MASK : tcc_pkg::A_DISC, 8'h00);
        end
        // match spacing is 65 ticks of 2^p bus cycles
        for (int p = 0; p < 3; p++) begin
            wr(tcc_pkg::A_SC2, 8'h08 | p[7:0]);
            wr(tcc_pkg::A_FLG1, 8'h02);
            wait_ch1(ta);
            wr(tcc_pkg::A_FLG1, 8'h02);
            wait_ch1(ta);
            wr(tcc_pkg::A_FLG1, 8'h02);
            wait_ch1(tb);
            chk("match period", 16'(65 << p), 16'(tb - ta));
        end
        end_test("compare");
        // free run to the wrap with overflow request enabled
        wr(tcc_pkg::A_TIE, 8'h00);
        wr(tcc_pkg::A_SC2, 8'h80);
        ta = 0;
        while (ovf_irq !== 1'b1 && ta < 70000) begin
            @(posedge clock);
            #1 ta++;
        end
        chk("overflow request", 16'h0001, {15'h0, ovf_irq});
        rd(tcc_pkg::A_FLG2, got);
        chk("overflow flag", 16'h0080, {8'h00, got});
        wr(tcc_pkg::A_SC2, 8'h00);
        #1 chk("overflow masked", 16'h0000, {15'h0, ovf_irq});
        wr(tcc_pkg::A_FLG2, 8'h7F);
        rd(tcc_pkg::A_FLG2, got);
        chk("overflow kept", 16'h0080, {8'h00, got});
        wr(tcc_pkg::A_FLG2, 8'h80);
        rd(tcc_pkg::A_FLG2, got);
        chk("overflow cleared", 16'h0000, {8'h00, got});
        end_test("overflow");
        report_and_stop();
    end
endmodule : tb_timer_compare_capture_ctrl
